// >>> include/prrp_consts.svh
// Register word indices, field positions and reset values of the block
`ifndef PRRP_CONSTS_SVH
`define PRRP_CONSTS_SVH

`define PRRP_OFF_ROUTE      8'h64
`define PRRP_OFF_OUTLVL     8'h65
`define PRRP_OFF_OUTINV     8'h66
`define PRRP_OFF_DIEID      8'h67
`define PRRP_OFF_PWR        8'h68
`define PRRP_OFF_AMUTE      8'h69
`define PRRP_OFF_PHASE      8'h6a
`define PRRP_OFF_SS0        8'h6b
`define PRRP_OFF_SS1        8'h6c
`define PRRP_OFF_STRAP      8'h80

`define PRRP_RST_BYTE       8'h00
// Arbitrary die identity value
`define PRRP_CHIP_IDENTITY_CODE 8'h5a

`define PRRP_RT_MISO_POS    6
`define PRRP_RT_SYNC_POS    4
`define PRRP_RT_RESET_POS   2
`define PRRP_RT_MUTE_POS    0

`define PRRP_PH_SEL_POS     2
`define PRRP_PH_SRC_POS     1
`define PRRP_PH_EN_POS      0

`define PRRP_SS_DIV2_POS    5
`define PRRP_SS_MAN_POS     4
`define PRRP_SS_RDM_POS     1
`define PRRP_SS_TRI_POS     0

`define PRRP_PIN_MASK       8'h07
`define PRRP_PHASE_STEP_DEG 45

`endif

// >>> include/prrp_pkg.sv
// Types of the pin/ramp block
package prrp_pkg;

  typedef enum logic [1:0] {
    PRRP_PWR_DEEP  = 2'b00,
    PRRP_PWR_SLEEP = 2'b01,
    PRRP_PWR_HIZ   = 2'b10,
    PRRP_PWR_PLAY  = 2'b11
  } prrp_pwr_t;

  typedef struct packed {
    logic [7:0]  route;
    logic [7:0]  outLvl;
    logic [7:0]  outInv;
    logic [7:0]  phase;
    logic [7:0]  ss0;
    logic [7:0]  ss1;
    logic [2:0]  pinS1;
    logic [2:0]  pinS2;
    logic [2:0]  pinS3;
    logic [2:0]  pinStable;
    logic [1:0]  muteSync;
    logic [1:0]  amuteSync;
    logic [1:0]  amuteS3;
    logic [1:0]  amuteStable;
    logic [1:0]  pwrS1;
    logic [1:0]  pwrSync;
    logic [1:0]  pwrS3;
    prrp_pwr_t   pwrStable;
    logic        dataPh;
    logic        dataWr;
    logic [7:0]  dataAddr;
    logic [31:0] hrdata;
    logic [2:0]  pinOut;
    logic        misoIn;
    logic        syncIn;
    logic        resetReq;
    logic        hizReq;
    logic [1:0]  rampPhase;
    logic        syncEn;
    logic        syncInternal;
    logic        ssManual;
    logic        ssDiv2;
    logic        ssRandom;
    logic        ssTriangle;
  } prrp_state_t;

endpackage : prrp_pkg

// >>> src/prrp_regs.sv
// Pin routing, ramp phase and spread-spectrum register group
// What this block does
// - Two-bit routing picks none, pin0, pin1, pin2
// - Routed mute pin forces high-impedance output
// - Invert bits flip driven levels of pins
// - Power report codes deep, sleep, hiz, play
// - Bit 1 shows right channel auto mute
// - Bit 0 shows left channel auto mute
// - Phase select picks ramp phase 0 to 3
// - Sync source bit: 0 pin, 1 internal
// - Bit 0 is the phase sync enable, passed out as is; sync pin routed regardless
// - Manual mode bit 5 selects PLL divided
// - Bit 4 selects manual spread-spectrum mode
`timescale 1ns/1ps
`default_nettype none
`include "prrp_consts.svh"

module prrp_regs (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [2:0]  pinIn,
  input  wire logic [1:0]  autoMuteIn,
  input  wire logic [1:0]  powerStateIn,
  output logic [2:0]       pinOutLevel,
  output logic             misoData,
  output logic             phaseSyncPin,
  output logic             pinResetReq,
  output logic             hizReq,
  output logic [1:0]       rampPhase,
  output logic             phaseSyncEn,
  output logic             phaseSyncInternal,
  output logic             ssManual,
  output logic             ssPllDiv2,
  output logic             ssRandomEn,
  output logic             ssTriangleEn
);

  prrp_pkg::prrp_state_t st_reg;
  prrp_pkg::prrp_state_t st_next;

  logic       addrTake;
  logic [7:0] rdByte;

  // Pin picked by a two-bit routing code
  function automatic logic pickPin(input logic [1:0] code,
                                   input logic [2:0] pins);
    logic r;
    r = 1'b0;
    case (code)
      2'b01:   r = pins[0];
      2'b10:   r = pins[1];
      2'b11:   r = pins[2];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pickPin

  assign addrTake = hsel && hready && htrans[1];

  always_comb
  begin
    st_next = st_reg;
    // Pin inputs: three stages, accept when stages two and three agree
    st_next.pinS1 = pinIn;
    st_next.pinS2 = st_reg.pinS1;
    st_next.pinS3 = st_reg.pinS2;
    for (int i = 0; i < 3; i++)
    begin
      if (st_reg.pinS2[i] == st_reg.pinS3[i])
      begin
        st_next.pinStable[i] = st_reg.pinS3[i];
      end
    end
    st_next.muteSync  = autoMuteIn;
    st_next.amuteSync = st_reg.muteSync;
    st_next.amuteS3   = st_reg.amuteSync;
    if (st_reg.amuteSync == st_reg.amuteS3)
    begin
      st_next.amuteStable = st_reg.amuteS3;
    end
    st_next.pwrS1   = powerStateIn;
    st_next.pwrSync = st_reg.pwrS1;
    st_next.pwrS3   = st_reg.pwrSync;
    if (st_reg.pwrSync == st_reg.pwrS3)
    begin
      st_next.pwrStable = prrp_pkg::prrp_pwr_t'(st_reg.pwrS3);
    end
    // Read mux
    case (st_reg.dataAddr)
      `PRRP_OFF_ROUTE:  rdByte = st_reg.route;
      `PRRP_OFF_OUTLVL: rdByte = st_reg.outLvl;
      `PRRP_OFF_OUTINV: rdByte = st_reg.outInv;
      `PRRP_OFF_DIEID:  rdByte = `PRRP_CHIP_IDENTITY_CODE;
      `PRRP_OFF_PWR:    rdByte = {6'h00, st_reg.pwrStable};
      `PRRP_OFF_AMUTE:  rdByte = {6'h00, st_reg.amuteStable};
      `PRRP_OFF_PHASE:  rdByte = st_reg.phase;
      `PRRP_OFF_SS0:    rdByte = st_reg.ss0;
      `PRRP_OFF_SS1:    rdByte = st_reg.ss1;
      default:          rdByte = 8'h00;
    endcase

    // Bus data phase
    st_next.hrdata = 32'h0000_0000;
    if (st_reg.dataPh && st_reg.dataWr)
    begin
      case (st_reg.dataAddr)
        `PRRP_OFF_ROUTE:  st_next.route  = hwdata[7:0];
        `PRRP_OFF_OUTLVL: st_next.outLvl = hwdata[7:0];
        `PRRP_OFF_OUTINV: st_next.outInv = hwdata[7:0];
        `PRRP_OFF_PHASE:  st_next.phase  = hwdata[7:0];
        `PRRP_OFF_SS0:    st_next.ss0    = hwdata[7:0];
        `PRRP_OFF_SS1:    st_next.ss1    = hwdata[7:0];
        default:          st_next.ss1    = st_reg.ss1;
      endcase
    end
    st_next.dataPh   = addrTake;
    st_next.dataWr   = addrTake && hwrite;
    st_next.dataAddr = addrTake ? haddr[9:2] : st_reg.dataAddr;
    if (addrTake && !hwrite)
    begin
      case (haddr[9:2])
        `PRRP_OFF_ROUTE:  st_next.hrdata = {24'h0, st_next.route};
        `PRRP_OFF_OUTLVL: st_next.hrdata = {24'h0, st_next.outLvl};
        `PRRP_OFF_OUTINV: st_next.hrdata = {24'h0, st_next.outInv};
        `PRRP_OFF_DIEID:  st_next.hrdata = {24'h0, `PRRP_CHIP_IDENTITY_CODE};
        `PRRP_OFF_PWR:    st_next.hrdata = {30'h0, st_next.pwrStable};
        `PRRP_OFF_AMUTE:  st_next.hrdata = {30'h0, st_next.amuteStable};
        `PRRP_OFF_PHASE:  st_next.hrdata = {24'h0, st_next.phase};
        `PRRP_OFF_SS0:    st_next.hrdata = {24'h0, st_next.ss0};
        `PRRP_OFF_SS1:    st_next.hrdata = {24'h0, st_next.ss1};
        default:          st_next.hrdata = {24'h0, rdByte & 8'h00};
      endcase
    end

    // Outputs from the committed registers
    st_next.pinOut = (st_next.outLvl[2:0] ^ st_next.outInv[2:0]);
    st_next.misoIn = pickPin(st_next.route[`PRRP_RT_MISO_POS +: 2],
                             st_reg.pinStable);
    st_next.syncIn = pickPin(st_next.route[`PRRP_RT_SYNC_POS +: 2],
                             st_reg.pinStable);
    // Reset and mute pins are active low
    st_next.resetReq = (st_next.route[`PRRP_RT_RESET_POS +: 2] != 2'b00) &&
      !pickPin(st_next.route[`PRRP_RT_RESET_POS +: 2],
               st_reg.pinStable);
    st_next.hizReq = (st_next.route[`PRRP_RT_MUTE_POS +: 2] != 2'b00) &&
      !pickPin(st_next.route[`PRRP_RT_MUTE_POS +: 2],
               st_reg.pinStable);
    st_next.rampPhase    = st_next.phase[`PRRP_PH_SEL_POS +: 2];
    st_next.syncEn       = st_next.phase[`PRRP_PH_EN_POS];
    st_next.syncInternal = st_next.phase[`PRRP_PH_SRC_POS];
    st_next.ssManual     = st_next.ss0[`PRRP_SS_MAN_POS];
    st_next.ssDiv2       = st_next.ss0[`PRRP_SS_MAN_POS] &&
                           st_next.ss0[`PRRP_SS_DIV2_POS];
    st_next.ssRandom     = st_next.ss0[`PRRP_SS_RDM_POS];
    st_next.ssTriangle   = st_next.ss0[`PRRP_SS_TRI_POS];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign hrdata            = st_reg.hrdata;
  assign pinOutLevel       = st_reg.pinOut;
  assign misoData          = st_reg.misoIn;
  assign phaseSyncPin      = st_reg.syncIn;
  assign pinResetReq       = st_reg.resetReq;
  assign hizReq            = st_reg.hizReq;
  assign rampPhase         = st_reg.rampPhase;
  assign phaseSyncEn       = st_reg.syncEn;
  assign phaseSyncInternal = st_reg.syncInternal;
  assign ssManual          = st_reg.ssManual;
  assign ssPllDiv2         = st_reg.ssDiv2;
  assign ssRandomEn        = st_reg.ssRandom;
  assign ssTriangleEn      = st_reg.ssTriangle;

  // Checks
  property p_inv;
    @(posedge mclk) disable iff (rst)
      pinOutLevel == (st_reg.outLvl[2:0] ^ st_reg.outInv[2:0]);
  endproperty
  a_inv: assert property (p_inv)
    else $error("pin invert wrong");

  property p_out_reg;
    @(posedge mclk) disable iff (rst)
      (st_reg.outInv[2:0] == 3'h0) |-> pinOutLevel == st_reg.outLvl[2:0];
  endproperty
  a_out_reg: assert property (p_out_reg)
    else $error("pin level not from register");

  property p_hiz;
    @(posedge mclk) disable iff (rst)
      (st_reg.route[1:0] == 2'h0) |-> !hizReq;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("hiz without mute pin");

  property p_hiz_pin;
    @(posedge mclk) disable iff (rst)
      (st_reg.route[1:0] == 2'h1 && !$past(st_reg.pinStable[0]))
        |-> hizReq;
  endproperty
  a_hiz_pin: assert property (p_hiz_pin)
    else $error("low mute pin without hiz");

  property p_route_none;
    @(posedge mclk) disable iff (rst)
      (st_reg.route[5:4] == 2'h0) |-> !phaseSyncPin;
  endproperty
  a_route_none: assert property (p_route_none)
    else $error("sync pin routed on code 00");

  property p_miso_none;
    @(posedge mclk) disable iff (rst)
      (st_reg.route[7:6] == 2'h0) |-> !misoData;
  endproperty
  a_miso_none: assert property (p_miso_none)
    else $error("data-in pin routed on code 00");

  property p_reset_none;
    @(posedge mclk) disable iff (rst)
      (st_reg.route[3:2] == 2'h0) |-> !pinResetReq;
  endproperty
  a_reset_none: assert property (p_reset_none)
    else $error("reset pin routed on code 00");

  property p_miso_pick;
    @(posedge mclk) disable iff (rst)
      (st_reg.route[7:6] == 2'h3)
        |-> misoData == $past(st_reg.pinStable[2]);
  endproperty
  a_miso_pick: assert property (p_miso_pick)
    else $error("data-in not from pin 2");

  property p_sync_pick;
    @(posedge mclk) disable iff (rst)
      (st_reg.route[5:4] == 2'h2)
        |-> phaseSyncPin == $past(st_reg.pinStable[1]);
  endproperty
  a_sync_pick: assert property (p_sync_pick)
    else $error("sync input not from pin 1");

  property p_pwr_rd;
    @(posedge mclk) disable iff (rst)
      (st_reg.dataPh && !st_reg.dataWr && st_reg.dataAddr == `PRRP_OFF_PWR)
        |-> hrdata == {30'h0, st_reg.pwrStable};
  endproperty
  a_pwr_rd: assert property (p_pwr_rd)
    else $error("power report read wrong");

  property p_amute_rd;
    @(posedge mclk) disable iff (rst)
      (st_reg.dataPh && !st_reg.dataWr && st_reg.dataAddr == `PRRP_OFF_AMUTE)
        |-> hrdata == {30'h0, st_reg.amuteStable};
  endproperty
  a_amute_rd: assert property (p_amute_rd)
    else $error("auto mute read wrong");

  property p_phase;
    @(posedge mclk) disable iff (rst)
      rampPhase == st_reg.phase[3:2];
  endproperty
  a_phase: assert property (p_phase)
    else $error("ramp phase wrong");

  property p_sync_en;
    @(posedge mclk) disable iff (rst)
      phaseSyncEn == st_reg.phase[0];
  endproperty
  a_sync_en: assert property (p_sync_en)
    else $error("sync enable wrong");

  property p_sync_src;
    @(posedge mclk) disable iff (rst)
      phaseSyncInternal == st_reg.phase[1];
  endproperty
  a_sync_src: assert property (p_sync_src)
    else $error("sync source wrong");

  property p_div2;
    @(posedge mclk) disable iff (rst)
      ssPllDiv2 |-> ssManual;
  endproperty
  a_div2: assert property (p_div2)
    else $error("div2 outside manual");

  property p_ss;
    @(posedge mclk) disable iff (rst)
      ssRandomEn == st_reg.ss0[1] && ssTriangleEn == st_reg.ss0[0];
  endproperty
  a_ss: assert property (p_ss)
    else $error("spread enables wrong");

  property p_man;
    @(posedge mclk) disable iff (rst)
      ssManual == st_reg.ss0[4];
  endproperty
  a_man: assert property (p_man)
    else $error("manual mode wrong");

endmodule : prrp_regs
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench of the pin routing and ramp register group
`timescale 1ns/1ps
`default_nettype none
`include "prrp_consts.svh"

module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  pinIn = 3'h0;
  logic [1:0]  autoMuteIn = 2'h0;
  logic [1:0]  powerStateIn = 2'h0;
  logic        hreadyout, hresp, misoData, phaseSyncPin, pinResetReq;
  logic        hizReq, phaseSyncEn, phaseSyncInternal, ssManual;
  logic        ssPllDiv2, ssRandomEn, ssTriangleEn;
  logic [31:0] hrdata;
  logic [2:0]  pinOutLevel;
  logic [1:0]  rampPhase;
  int          failures = 0;
  int          total_checks = 0;
  logic [7:0]  mreg [logic [7:0]];
  logic [7:0]  rwA [6];

  prrp_regs u_dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .pinIn, .autoMuteIn, .powerStateIn, .pinOutLevel,
    .misoData, .phaseSyncPin, .pinResetReq, .hizReq, .rampPhase,
    .phaseSyncEn, .phaseSyncInternal, .ssManual, .ssPllDiv2,
    .ssRandomEn, .ssTriangleEn);

  always #2.5 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // Bounded wait for hready, data taken at the same rising edge
  task automatic wait_ready(output logic [31:0] rd);
    int n;
    rd = 32'h0;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (hreadyout === 1'b1)
      begin
        rd = hrdata;
        break;
      end
    end
    if (n == 20)
    begin
      failures++;
      final_report();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, a, 2'h0};
    wait_ready(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready(rd);
    if (wr && mreg.exists(a))
      mreg[a] = d;
  endtask : bus

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      `PRRP_OFF_DIEID: exp_rd = {24'h0, `PRRP_CHIP_IDENTITY_CODE};
      `PRRP_OFF_PWR:   exp_rd = {30'h0, powerStateIn};
      `PRRP_OFF_AMUTE: exp_rd = {30'h0, autoMuteIn};
      default:         exp_rd = mreg.exists(a) ? {24'h0, mreg[a]} : 32'h0;
    endcase
  endfunction : exp_rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] r;
    bus(1'b0, a, 8'h0, r);
    chk(r, exp_rd(a));
    chk(hresp, 1'b0);
  endtask : rd_chk

  function automatic logic pick(input logic [1:0] c);
    pick = (c == 2'h0) ? 1'b0 : pinIn[c - 2'h1];
  endfunction : pick

  task automatic chk_outs;
    logic [7:0] r;
    logic [7:0] p;
    logic [7:0] s;
    r = mreg[`PRRP_OFF_ROUTE];
    p = mreg[`PRRP_OFF_PHASE];
    s = mreg[`PRRP_OFF_SS0];
    repeat (8) @(posedge mclk);
    chk(misoData, pick(r[7:6]));
    chk(phaseSyncPin, pick(r[5:4]));
    chk(pinResetReq, (r[3:2] != 2'h0) && !pick(r[3:2]));
    chk(hizReq, (r[1:0] != 2'h0) && !pick(r[1:0]));
    chk(pinOutLevel, mreg[`PRRP_OFF_OUTLVL][2:0]
        ^ mreg[`PRRP_OFF_OUTINV][2:0]);
    chk(rampPhase, p[3:2]);
    chk(phaseSyncInternal, p[1]);
    chk(phaseSyncEn, p[0]);
    chk(ssPllDiv2, s[5] & s[4]);
    chk(ssManual, s[4]);
    chk({ssRandomEn, ssTriangleEn}, s[1:0]);
  endtask : chk_outs

  initial
  begin
    int i;
    int k;
    logic [31:0] d;
    void'($urandom(44664));
    rwA = '{`PRRP_OFF_ROUTE, `PRRP_OFF_OUTLVL, `PRRP_OFF_OUTINV,
            `PRRP_OFF_PHASE, `PRRP_OFF_SS0, `PRRP_OFF_SS1};
    foreach (rwA[j])
      mreg[rwA[j]] = `PRRP_RST_BYTE;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (i = 'h64; i <= 'h6c; i++)
      rd_chk(i[7:0]);
    rd_chk(8'h70);
    chk_outs();
    $display("test reset values done");
    for (k = 0; k < 12; k++)
    begin
      foreach (rwA[j])
      begin
        d = $urandom;
        wr(rwA[j], d[7:0]);
        rd_chk(rwA[j]);
      end
      chk_outs();
    end
    $display("test register access done");
    for (k = 0; k < 32; k++)
    begin
      d = $urandom;
      pinIn <= d[10:8];
      wr(`PRRP_OFF_ROUTE, d[7:0]);
      chk_outs();
    end
    $display("test pin routing done");
    wr(`PRRP_OFF_PHASE, 8'h0d);
    wr(`PRRP_OFF_SS0, 8'h03);
    for (k = 0; k < 4; k++)
    begin
      powerStateIn <= k[1:0];
      autoMuteIn <= ~k[1:0];
      repeat (8) @(posedge mclk);
      rd_chk(`PRRP_OFF_PWR);
      rd_chk(`PRRP_OFF_AMUTE);
    end
    $display("test status reports done");
    wr(`PRRP_OFF_DIEID, 8'hff);
    wr(`PRRP_OFF_PWR, 8'hff);
    wr(`PRRP_OFF_AMUTE, 8'hff);
    wr(8'h70, 8'hff);
    for (i = 'h67; i <= 'h70; i++)
      rd_chk(i[7:0]);
    $display("test read-only writes done");
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    foreach (rwA[j])
      mreg[rwA[j]] = `PRRP_RST_BYTE;
    foreach (rwA[j])
      rd_chk(rwA[j]);
    chk_outs();
    $display("test second reset done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
